// *** t16b_pkg.sv ***
// shared constants for the byte-access timer and its controller
package t16b_pkg;
	// byte addresses on the timer's own byte bus
	localparam logic [2:0] A_CTL_FIRST  = 3'h0;
	localparam logic [2:0] A_CTL_SECOND = 3'h1;
	localparam logic [2:0] A_CNT_LO     = 3'h2;
	localparam logic [2:0] A_CNT_HI     = 3'h3;
	localparam logic [2:0] A_CAP_LO     = 3'h4;
	localparam logic [2:0] A_CAP_HI     = 3'h5;
	localparam logic [2:0] A_FLAG       = 3'h6;
	localparam logic [2:0] A_MASK       = 3'h7;
	localparam logic [2:0] A_UPPER      = 3'h1;  // or-ed in to reach the upper half
	// control field positions
	localparam int TSEL_LSB  = 0;   // tick_source_select in control_second
	localparam int TSEL_MSB  = 2;
	localparam int TOPCAP    = 3;   // control_second: top from capture_value
	localparam int CAP_RISE  = 6;   // control_second: capture on rising edge
	localparam int FILT_EN   = 7;   // control_second: noise filter on
	localparam int TOP_LSB   = 0;   // control_first: fixed top choice
	localparam int TOP_MSB   = 1;
	// flag and mask bit positions
	localparam int F_OVF = 0;
	localparam int F_CAP = 1;
	// tick source codes
	localparam logic [2:0] TS_NONE = 3'h0;
	localparam logic [2:0] TS_DIV1 = 3'h1;
	localparam logic [2:0] TS_DIV8 = 3'h2;
	localparam logic [2:0] TS_D64  = 3'h3;
	localparam logic [2:0] TS_D256 = 3'h4;
	localparam logic [2:0] TS_D1K  = 3'h5;
	localparam logic [2:0] TS_FALL = 3'h6;
	localparam logic [2:0] TS_RISE = 3'h7;
	// prescaler tap masks
	localparam logic [9:0] PM_8   = 10'h007;
	localparam logic [9:0] PM_64  = 10'h03F;
	localparam logic [9:0] PM_256 = 10'h0FF;
	localparam logic [9:0] PM_1K  = 10'h3FF;
	localparam logic [9:0] PRE_ZERO = 10'h000;
	// count boundaries
	localparam logic [15:0] CNT_FLOOR = 16'h0000;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [15:0] TOP_8     = 16'h00FF;
	localparam logic [15:0] TOP_9     = 16'h01FF;
	localparam logic [15:0] TOP_10    = 16'h03FF;
	localparam int FILT_LEN = 4;   // equal samples the noise filter demands
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// controller register word offsets
	localparam logic [7:0] W_DATA   = 8'h00;
	localparam logic [7:0] W_CMD    = 8'h04;
	localparam logic [7:0] W_STATUS = 8'h08;
	localparam logic [7:0] W_RDATA  = 8'h0C;
	localparam logic [7:0] W_POWER  = 8'h10;
	// command word fields
	localparam int C_ADR_LSB = 0;
	localparam int C_ADR_MSB = 2;
	localparam int C_READ    = 4;
	localparam int C_WIDE    = 5;
	localparam int C_REUSE   = 6;
	localparam int S_BUSY    = 0;
	localparam int S_IRQ     = 1;
	localparam logic PG_RESET = 1'b1;   // timer gated off after reset
endpackage

// *** t16b_if.sv ***
// byte-wide processor bus between controller and timer
`timescale 1ns/1ns
`default_nettype none
interface t16b_if;
	logic       power_gate;  // timer_power_gate, high keeps timer off
	logic [2:0] addr;
	logic       wr;          // one-cycle write strobe
	logic       rd;          // one-cycle read strobe
	logic [7:0] wdata;
	logic [7:0] rdata;       // valid the cycle after rd
	logic       irq;         // masked timer interrupt request
	modport ctrl  (output power_gate, addr, wr, rd, wdata, input rdata, irq);
	modport timer (input power_gate, addr, wr, rd, wdata, output rdata, irq);
endinterface
`default_nettype wire

// *** t16b_timer.sv ***
// reduced 16-bit timer with shared high-byte latch on a byte bus
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module t16b_timer
	import t16b_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// processor side
	t16b_if.timer     bus,
	// pins
	input  wire logic ext_count_pin_i,
	input  wire logic capture_pin_i,
	// boundary status
	output logic      count_floor_o,
	output logic      count_max_o
);
	logic [7:0]          ctl_first;
	logic [7:0]          ctl_second;
	logic [7:0]          flags;
	logic [7:0]          mask;
	logic [7:0]          hi_latch;
	logic [15:0]         count_value;
	logic [15:0]         capture_value;
	logic [9:0]          pre_cnt;
	logic                ext_s1;
	logic                ext_s2;
	logic                ext_prev;
	logic                cap_s1;
	logic                cap_s2;
	logic [FILT_LEN-1:0] filt;
	logic                cap_f;
	logic                cap_prev;
	logic                cap_in;
	logic                timer_tick;
	logic [15:0]         top;
	logic [2:0]          tsel;
	logic                top_cap;
	logic                gated;
	logic                at_top;
	logic                ovf_evt;
	logic                cap_evt;
	logic                wr_cnt_lo;
	logic                wr_cap_lo;
	logic [7:0]          flag_clr;

	assign tsel    = ctl_second[TSEL_MSB:TSEL_LSB];
	assign top_cap = ctl_second[TOPCAP];
	assign gated   = bus.power_gate;
	// 16-bit loads happen only on the low-byte strobe
	assign wr_cnt_lo = bus.wr && (bus.addr == A_CNT_LO);
	assign wr_cap_lo = bus.wr && (bus.addr == A_CAP_LO) && top_cap;

	// two-stage synchronisers for both pins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
		end
		else
		begin
			ext_s1 <= ext_count_pin_i;
			ext_s2 <= ext_s1;
			cap_s1 <= capture_pin_i;
			cap_s2 <= cap_s1;
		end
	end

	// prescaler runs while any tick source other than none is selected and the timer is not gated
	always_ff @(posedge clk_i)
	begin
		if (rst_i || gated || (tsel == TS_NONE))
			pre_cnt <= PRE_ZERO;
		else
			pre_cnt <= pre_cnt + 10'h001;
	end

	// previous synchronised pin level for edge detection
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ext_prev <= 1'b0;
		else
			ext_prev <= ext_s2;
	end

	// tick source and edge selection
	always_comb
	begin
		unique case (tsel)
			TS_NONE: timer_tick = 1'b0;
			TS_DIV1: timer_tick = 1'b1;
			TS_DIV8: timer_tick = ((pre_cnt & PM_8) == PM_8);
			TS_D64:  timer_tick = ((pre_cnt & PM_64) == PM_64);
			TS_D256: timer_tick = ((pre_cnt & PM_256) == PM_256);
			TS_D1K:  timer_tick = ((pre_cnt & PM_1K) == PM_1K);
			TS_FALL: timer_tick = ext_prev && !ext_s2;
			TS_RISE: timer_tick = !ext_prev && ext_s2;
		endcase
	end

	// top of sequence from mode
	always_comb
	begin
		if (top_cap)
			top = capture_value;
		else
		begin
			unique case (ctl_first[TOP_MSB:TOP_LSB])
				2'h0: top = CNT_MAX;
				2'h1: top = TOP_8;
				2'h2: top = TOP_9;
				2'h3: top = TOP_10;
			endcase
		end
	end

	assign at_top  = (count_value == top);
	assign ovf_evt = timer_tick && at_top && !gated && !wr_cnt_lo;
	// boundary comparators on the counter register
	assign count_floor_o = (count_value == CNT_FLOOR);
	assign count_max_o   = (count_value == CNT_MAX);

	// counter: processor write first, then clear at top or count
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			count_value <= CNT_FLOOR;
		else if (wr_cnt_lo)
			count_value <= {hi_latch, bus.wdata};
		else if (timer_tick && !gated)
		begin
			if (at_top)
				count_value <= CNT_FLOOR;
			else
				count_value <= count_value + 16'h0001;
		end
	end

	// noise filter: output follows input only after equal samples
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			filt  <= '0;
			cap_f <= 1'b0;
		end
		else
		begin
			filt <= {filt[FILT_LEN-2:0], cap_s2};
			if (filt == {FILT_LEN{1'b1}})
				cap_f <= 1'b1;
			else if (filt == {FILT_LEN{1'b0}})
				cap_f <= 1'b0;
		end
	end

	assign cap_in  = ctl_second[FILT_EN] ? cap_f : cap_s2;
	// capture input is idle while capture_value defines the top
	assign cap_evt = !gated && !top_cap
		&& (ctl_second[CAP_RISE] ? (cap_in && !cap_prev) : (!cap_in && cap_prev));

	// capture edge detector history
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cap_prev <= 1'b0;
		else
			cap_prev <= cap_in;
	end

	// capture register: edge copy, or processor load in top mode
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			capture_value <= CNT_FLOOR;
		else if (cap_evt)
			capture_value <= count_value;
		else if (wr_cap_lo)
			capture_value <= {hi_latch, bus.wdata};
	end

	// shared high-byte latch
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hi_latch <= BYTE_ZERO;
		else if (bus.rd && (bus.addr == A_CNT_LO))
			hi_latch <= count_value[15:8];
		else if (bus.rd && (bus.addr == A_CAP_LO))
			hi_latch <= capture_value[15:8];
		else if (bus.wr && ((bus.addr == A_CNT_HI) || (bus.addr == A_CAP_HI)))
			hi_latch <= bus.wdata;
	end

	// control registers, plain byte writes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctl_first  <= BYTE_ZERO;
			ctl_second <= BYTE_ZERO;
			mask       <= BYTE_ZERO;
		end
		else if (bus.wr)
		begin
			if (bus.addr == A_CTL_FIRST)
				ctl_first <= bus.wdata;
			if (bus.addr == A_CTL_SECOND)
				ctl_second <= bus.wdata;
			if (bus.addr == A_MASK)
				mask <= bus.wdata;
		end
	end

	// flags: write one clears, a new event wins over the clear
	assign flag_clr = (bus.wr && (bus.addr == A_FLAG)) ? bus.wdata : BYTE_ZERO;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flags <= BYTE_ZERO;
		else
		begin
			flags <= flags & ~flag_clr;
			if (ovf_evt)
				flags[F_OVF] <= 1'b1;
			if (cap_evt)
				flags[F_CAP] <= 1'b1;
		end
	end

	assign bus.irq = |(flags & mask);

	// read data: registered, valid the cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bus.rdata <= BYTE_ZERO;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				A_CTL_FIRST:  bus.rdata <= ctl_first;
				A_CTL_SECOND: bus.rdata <= ctl_second;
				A_CNT_LO:     bus.rdata <= count_value[7:0];
				A_CAP_LO:     bus.rdata <= capture_value[7:0];
				A_CNT_HI,
				A_CAP_HI:     bus.rdata <= hi_latch;
				A_FLAG:       bus.rdata <= flags;
				A_MASK:       bus.rdata <= mask;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** t16b_ctrl.sv ***
// controller: wishbone slave issuing ordered byte accesses to the timer
`timescale 1ns/1ns
`default_nettype none
module t16b_ctrl
	import t16b_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// timer side
	t16b_if.ctrl             bus
);
	typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW, ST_TAIL} t16b_state_t;

	t16b_state_t state;
	logic [15:0] wdata16;
	logic [15:0] rdata16;
	logic [2:0]  op_addr;
	logic        op_read;
	logic        op_wide;
	logic        op_reuse;
	logic        power_gate;
	logic        acc;
	logic        start;

	assign acc   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// commands arriving while busy are dropped, keeping pairs unbroken
	assign start = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == W_CMD)
		&& (state == ST_IDLE);

	// wishbone acknowledge one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= acc;
	end

	// write data and power gate registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wdata16    <= 16'h0000;
			power_gate <= PG_RESET;
		end
		else if (acc && wb_we_i)
		begin
			if (wb_adr_i == W_DATA && wb_sel_i[0])
				wdata16[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i == W_DATA && wb_sel_i[1])
				wdata16[15:8] <= wb_dat_i[15:8];
			if (wb_adr_i == W_POWER && wb_sel_i[0])
				power_gate <= wb_dat_i[0];
		end
	end

	// latched command
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			op_addr  <= 3'h0;
			op_read  <= 1'b0;
			op_wide  <= 1'b0;
			op_reuse <= 1'b0;
		end
		else if (start)
		begin
			op_addr  <= wb_dat_i[C_ADR_MSB:C_ADR_LSB];
			op_read  <= wb_dat_i[C_READ];
			op_wide  <= wb_dat_i[C_WIDE];
			op_reuse <= wb_dat_i[C_REUSE];
		end
	end

	// sequencer: writes high then low, reads low then high
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE:
					if (start)
					begin
						if (!wb_dat_i[C_READ] && wb_dat_i[C_WIDE] && !wb_dat_i[C_REUSE])
							state <= ST_HIGH;
						else
							state <= ST_LOW;
					end
				ST_HIGH: state <= op_read ? ST_TAIL : ST_LOW;
				ST_LOW:  state <= op_read ? (op_wide ? ST_HIGH : ST_TAIL) : ST_IDLE;
				ST_TAIL: state <= ST_IDLE;
			endcase
		end
	end

	// read result collection
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata16 <= 16'h0000;
		else if (state == ST_HIGH && op_read)
			rdata16[7:0] <= bus.rdata;
		else if (state == ST_TAIL && op_wide)
			rdata16[15:8] <= bus.rdata;
		else if (state == ST_TAIL)
			rdata16 <= {BYTE_ZERO, bus.rdata};
	end

	// byte bus drive
	assign bus.power_gate = power_gate;
	assign bus.wr    = !op_read && (state == ST_HIGH || state == ST_LOW);
	assign bus.rd    = op_read && (state == ST_HIGH || state == ST_LOW);
	assign bus.addr  = (state == ST_HIGH) ? (op_addr | A_UPPER) : op_addr;
	assign bus.wdata = (state == ST_HIGH) ? wdata16[15:8] : wdata16[7:0];

	// register read data
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h00000000;
		else if (acc && !wb_we_i)
		begin
			unique case (wb_adr_i)
				W_DATA:   wb_dat_o <= {16'h0000, wdata16};
				W_CMD:    wb_dat_o <= {25'h0000000, op_reuse, op_wide, op_read, 1'b0, op_addr};
				W_STATUS: wb_dat_o <= {30'h00000000, bus.irq, state != ST_IDLE};
				W_RDATA:  wb_dat_o <= {16'h0000, rdata16};
				W_POWER:  wb_dat_o <= {31'h00000000, power_gate};
				default:  wb_dat_o <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** t16b_assertions.sv ***
// checker for the byte bus between controller and timer
`timescale 1ns/1ns
`default_nettype none
module t16b_assertions
	import t16b_pkg::*;
(
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// byte bus
	input wire logic       power_gate,
	input wire logic [2:0] addr,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       irq
);
	logic [7:0] lat;
	logic       lat_ok;
	logic [7:0] ctl [2];
	logic [7:0] msk;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// mirror of the shared latch while only high writes touched it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			lat_ok <= 1'b0;
		else if (wr && (addr == A_CNT_HI || addr == A_CAP_HI))
		begin
			lat_ok <= 1'b1;
			lat <= wdata;
		end
		else if (rd && (addr == A_CNT_LO || addr == A_CAP_LO))
			lat_ok <= 1'b0;
	end
	// mirror of control and mask bytes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctl <= '{8'h00, 8'h00};
			msk <= 8'h00;
		end
		else if (wr && addr[2:1] == 2'b00)
			ctl[addr[0]] <= wdata;
		else if (wr && addr == A_MASK)
			msk <= wdata;
	end
	a_no_wr_rd: assert property (!(wr && rd))
		else $error("read and write strobes together");
	a_wr_high_first: assert property ($past(wr) && wr |->
		!addr[0] && $past(addr[0]) && addr[2:1] == $past(addr[2:1]))
		else $error("wide write not high then low");
	a_rd_low_first: assert property ($past(rd) && rd |->
		addr[0] && !$past(addr[0]) && addr[2:1] == $past(addr[2:1]))
		else $error("wide read not low then high");
	a_two_writes: assert property (wr ##1 wr |=> !wr)
		else $error("more than two write strobes");
	a_two_reads: assert property (rd [*2] |=> !rd)
		else $error("more than two read strobes");
	a_rdata_after_rd: assert property (!$stable(rdata) |-> $past(rd))
		else $error("read byte changed without a read");
	a_latch_holds: assert property (rd && addr == A_CNT_HI && lat_ok |=> rdata == lat)
		else $error("count upper read lost latch value");
	a_latch_shared: assert property (rd && addr == A_CAP_HI && lat_ok |=> rdata == lat)
		else $error("capture upper read not from latch");
	a_ctl_byte: assert property (rd && addr[2:1] == 2'b00 |=> rdata == ctl[$past(addr[0])])
		else $error("control byte read back wrong");
	a_irq_masked: assert property (msk == 8'h00 |-> !irq)
		else $error("request raised with all masked");
	a_gate_irq_quiet: assert property (power_gate && !irq && !wr |=> !irq)
		else $error("request raised while timer gated");
	c_wide_wr: cover property (wr ##1 wr);
	c_wide_rd: cover property (rd ##1 rd);
	c_irq: cover property (irq);
endmodule
`default_nettype wire

// *** tb_timer16_byte_access_core.sv ***
// self-checking bench for the byte-access timer and its controller
`timescale 1ns/1ns
`default_nettype none
module tb_timer16_byte_access_core
	import t16b_pkg::*;
;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] got;
	logic        ack;
	logic        ext_pin;
	logic        cap_pin;
	logic        floor_f;
	logic        max_f;
	int          error_cnt;
	int          n_compared;
	int          dv [6] = '{1, 1, 8, 64, 256, 1024};
	logic [15:0] cv [2] = '{16'h0003, 16'h00C8};
	logic [15:0] tp [5] = '{CNT_MAX, TOP_8, TOP_9, TOP_10, 16'h0040};  // last: capture top
	t16b_if      bus ();
	t16b_ctrl t16b_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .bus(bus.ctrl));
	t16b_timer t16b_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus.timer),
		.ext_count_pin_i(ext_pin), .capture_pin_i(cap_pin), .count_floor_o(floor_f),
		.count_max_o(max_f));
	t16b_assertions t16b_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
		.power_gate(bus.power_gate), .addr(bus.addr), .wr(bus.wr), .rd(bus.rd),
		.wdata(bus.wdata), .rdata(bus.rdata), .irq(bus.irq));
	// free-running clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic end_sim;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk16({15'h0, g}, {15'h0, e});
	endtask
	// one classic wishbone cycle, held until ack
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			error_cnt++;
			$display("Error at %0t ack %h expected %h", $time, ack, 1'b1);
			end_sim();
		end
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// timer access through the controller; m is {reuse, wide}
	task automatic acc(input logic [2:0] a, input logic r, input logic [1:0] m,
		input logic [15:0] d);
		int n;
		if (!r)
			wb(W_DATA, 1'b1, {16'h0, d});
		wb(W_CMD, 1'b1, {25'h0, m, r, 1'b0, a});
		n = 0;
		do
		begin
			wb(W_STATUS, 1'b0, 32'h0);
			n++;
		end
		while (got[S_BUSY] !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			error_cnt++;
			$display("Error at %0t busy %h expected %h", $time, got[S_BUSY], 1'b0);
			end_sim();
		end
		if (r)
			wb(W_RDATA, 1'b0, 32'h0);
	endtask
	// pulse a pin high for h cycles
	task automatic pulse(input int pin, input int h);
		if (pin == 0)
			ext_pin <= 1'b1;
		else
			cap_pin <= 1'b1;
		repeat (h) @(posedge clk_i);
		ext_pin <= 1'b0;
		cap_pin <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	// main sequence
	initial
	begin
		error_cnt = 0;
		n_compared = 0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		ext_pin = 1'b0;
		cap_pin = 1'b0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(W_POWER, 1'b0, 32'h0);
		chk16(got[15:0], 16'h0001);
		wb(8'h14, 1'b0, 32'h0);
		chk16(got[15:0], 16'h0000);
		wb(W_POWER, 1'b1, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			acc(3'(i), 1'b0, 2'b00, cv[i]);
			acc(3'(i), 1'b1, 2'b00, 16'h0);
			chk16({8'h00, got[7:0]}, cv[i]);
		end
		acc(A_CTL_FIRST, 1'b0, 2'b00, 16'h0000);
		acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0000);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'h01FF);
		repeat (10) @(posedge clk_i);
		acc(A_CNT_LO, 1'b1, 2'b01, 16'h0);
		chk16(got[15:0], 16'h01FF);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'hA5C3);
		acc(A_CNT_HI, 1'b1, 2'b00, 16'h0);
		chk16({8'h00, got[7:0]}, 16'h00A5);
		acc(A_CNT_LO, 1'b1, 2'b01, 16'h0);
		chk16(got[15:0], 16'hA5C3);
		// one upper write serves counter and capture
		acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0008);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'h3C11);
		acc(A_CAP_LO, 1'b0, 2'b11, 16'h0022);
		acc(A_CAP_HI, 1'b1, 2'b00, 16'h0);
		chk16({8'h00, got[7:0]}, 16'h003C);
		acc(A_CAP_LO, 1'b1, 2'b01, 16'h0);
		chk16(got[15:0], 16'h3C22);
		acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0000);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'hFFFF);
		chk1(max_f, 1'b1);
		chk1(floor_f, 1'b0);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'h0000);
		chk1(floor_f, 1'b1);
		chk1(max_f, 1'b0);
		// wrap at the 8-, 9- and 10-bit fixed tops and at the capture top, then flag and mask
		acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0008);
		acc(A_CAP_LO, 1'b0, 2'b01, tp[4]);
		for (int t = 1; t < 5; t++)
		begin
			acc(A_FLAG, 1'b0, 2'b00, 16'h0003);
			acc(A_CTL_FIRST, 1'b0, 2'b00, 16'(t));
			acc(A_CNT_LO, 1'b0, 2'b01, tp[t] - 16'h000F);
			acc(A_CTL_SECOND, 1'b0, 2'b00, {12'h0, t == 4, TS_DIV1});
			repeat (40) @(posedge clk_i);
			acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0000);
			acc(A_CNT_LO, 1'b1, 2'b01, 16'h0);
			chk1(got[15:0] < tp[t] - 16'h000F, 1'b1);
			acc(A_FLAG, 1'b1, 2'b00, 16'h0);
			chk1(got[F_OVF], 1'b1);
		end
		chk1(bus.irq, 1'b0);
		acc(A_MASK, 1'b0, 2'b00, 16'h0001);
		chk1(bus.irq, 1'b1);
		acc(A_FLAG, 1'b0, 2'b00, 16'h0001);
		chk1(bus.irq, 1'b0);
		acc(A_MASK, 1'b0, 2'b00, 16'h0000);
		acc(A_CTL_FIRST, 1'b0, 2'b00, 16'h0000);
		// prescaled ticks, then external edges
		for (int k = 2; k < 8; k++)
		begin
			acc(A_CNT_LO, 1'b0, 2'b01, 16'h0000);
			acc(A_CTL_SECOND, 1'b0, 2'b00, 16'(k));
			if (k < 6)
				repeat (2048) @(posedge clk_i);
			else
				repeat (3) pulse(0, 4);
			repeat (8) @(posedge clk_i);
			acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0000);
			acc(A_CNT_LO, 1'b1, 2'b01, 16'h0);
			if (k < 6)
				chk1(got[15:0] >= 2048 / dv[k] && got[15:0] <= 2200 / dv[k] + 1, 1'b1);
			else
				chk16(got[15:0], 16'h0003);
		end
		// capture on rising edge, then filtered spike and long level
		acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0040);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'h1234);
		acc(A_FLAG, 1'b0, 2'b00, 16'h0003);
		pulse(1, 10);
		acc(A_FLAG, 1'b1, 2'b00, 16'h0);
		chk1(got[F_CAP], 1'b1);
		acc(A_CAP_LO, 1'b1, 2'b01, 16'h0);
		chk16(got[15:0], 16'h1234);
		acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h00C0);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'h0077);
		acc(A_FLAG, 1'b0, 2'b00, 16'h0003);
		pulse(1, 2);
		repeat (8) @(posedge clk_i);
		acc(A_FLAG, 1'b1, 2'b00, 16'h0);
		chk1(got[F_CAP], 1'b0);
		pulse(1, 12);
		acc(A_FLAG, 1'b1, 2'b00, 16'h0);
		chk1(got[F_CAP], 1'b1);
		acc(A_CAP_LO, 1'b1, 2'b01, 16'h0);
		chk16(got[15:0], 16'h0077);
		// capture on a falling edge without the filter
		acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0000);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'h0055);
		pulse(1, 10);
		acc(A_CAP_LO, 1'b1, 2'b01, 16'h0);
		chk16(got[15:0], 16'h0055);
		// gated timer keeps its count while registers stay reachable
		wb(W_POWER, 1'b1, 32'h1);
		acc(A_CNT_LO, 1'b0, 2'b01, 16'h0100);
		acc(A_CTL_SECOND, 1'b0, 2'b00, {13'h0, TS_DIV1});
		repeat (20) @(posedge clk_i);
		acc(A_CTL_SECOND, 1'b0, 2'b00, 16'h0000);
		wb(W_POWER, 1'b1, 32'h0);
		acc(A_CNT_LO, 1'b1, 2'b01, 16'h0);
		chk16(got[15:0], 16'h0100);
		end_sim();
	end
endmodule
`default_nettype wire
